// ==== core/pia_regs.sv ====
// PHY identifier and auto-negotiation advertisement registers behind APB.
// Assumes strap pins are asynchronous to pclk and settle before presetn rises.
//
// Function
// - First identifier register returns organisation id bits 3..18, read-only.
// - Second identifier bits 15:10 return organisation id bits 19..24.
// - Second identifier bits 9:4 hold six-bit vendor model number.
// - Second identifier bits 3:0 hold four-bit revision number.
// - Advertisement register contents form the ability word sent to partner.
// - Bit 15 next page request, read-write, resets to 0.
// - Bit 14 reserved, writes ignored, reads 0.
// - Bit 13 remote fault advert, read-write, resets to 0.
// - Bits 12:11 reserved, software writes 0, read as 0.
// - Bit 10 pause ability, read-write, reset from pause strap.
// - Bit 9 T4 ability fixed 0, read-only.
// - Bits 8, 7 fast abilities, read-write, reset from straps.
// - Bits 6, 5 slow abilities, read-write, reset from straps.
// - Bits 4:0 selector, read-write, resets to 00001.
`timescale 1ns/10ps
`default_nettype none

module pia_regs #(
  parameter logic [15:0] ORG_ID_HIGH = 16'h1234, // Arbitrary value
  parameter logic [5:0]  ORG_ID_LOW  = 6'h15,    // Arbitrary value
  parameter logic [5:0]  MODEL_NUM   = 6'h0a,    // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h1      // Arbitrary value
) (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Strap pins
  input  wire pia_pkg::pia_strap_type strap_pins,
  // Ability word toward the auto-negotiation engine
  output logic      [15:0]            advert_word
);

  // ----------------------------------------------------------------
  // Strap synchroniser and capture
  // ----------------------------------------------------------------
  pia_pkg::pia_strap_type strap_meta_ff;
  pia_pkg::pia_strap_type strap_sync_ff;
  logic                   strap_loaded_ff;
  logic [15:0]            adv_ff;
  logic [15:0]            nxt_adv;
  logic                   wr_adv;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta_ff <= '0;
      strap_sync_ff <= '0;
    end else begin
      strap_meta_ff <= strap_pins;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // Straps are loaded once, on the third edge after release, when the sync stage is valid
  logic [1:0] load_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt_ff     <= 2'h0;
      strap_loaded_ff <= 1'b0;
    end else begin
      if (load_cnt_ff != 2'h2) begin
        load_cnt_ff <= load_cnt_ff + 2'h1;
      end
      if (load_cnt_ff == 2'h2) begin
        strap_loaded_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Advertisement register
  // ----------------------------------------------------------------
  assign wr_adv = psel && penable && pwrite && (paddr == pia_pkg::ADDR_AUTONEG_ADVERTISEMENT);

  always_comb begin
    nxt_adv = adv_ff;
    if (load_cnt_ff == 2'h2 && !strap_loaded_ff) begin
      nxt_adv[pia_pkg::ADV_PAUSE_BIT]   = strap_sync_ff.pause_en;
      nxt_adv[pia_pkg::ADV_FAST_FD_BIT] = strap_sync_ff.fast_fd;
      nxt_adv[pia_pkg::ADV_FAST_HD_BIT] = strap_sync_ff.fast_hd;
      nxt_adv[pia_pkg::ADV_SLOW_FD_BIT] = strap_sync_ff.slow_fd;
      nxt_adv[pia_pkg::ADV_SLOW_HD_BIT] = strap_sync_ff.slow_hd;
    end
    // A write in the load cycle wins: software overrides strap defaults
    if (wr_adv) begin
      if (pstrb[0]) begin
        nxt_adv[7:0] = pwdata[7:0] & pia_pkg::ADV_WRITE_MASK[7:0];
      end
      if (pstrb[1]) begin
        nxt_adv[15:8] = pwdata[15:8] & pia_pkg::ADV_WRITE_MASK[15:8];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_ff <= {11'h000, pia_pkg::SELECTOR_RESET};
    end else begin
      adv_ff <= nxt_adv;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      advert_word <= {11'h000, pia_pkg::SELECTOR_RESET};
    end else begin
      advert_word <= nxt_adv;
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  pia_pkg::pia_id_low_type id_low;
  assign id_low = '{org_id_low_bits: ORG_ID_LOW, vendor_model_number: MODEL_NUM, model_revision_number: REVISION};

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == pia_pkg::ADDR_PHY_IDENTIFIER_HIGH) || (a == pia_pkg::ADDR_PHY_IDENTIFIER_LOW) ||
               (a == pia_pkg::ADDR_AUTONEG_ADVERTISEMENT);
  endfunction : addr_hit

  // Zero-wait slave: pready rises in the first access cycle
  logic setup;
  assign setup = psel && !penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addr_hit(paddr);
      if (setup && !pwrite) begin
        unique case (paddr)
          pia_pkg::ADDR_PHY_IDENTIFIER_HIGH:   prdata <= {16'h0000, ORG_ID_HIGH};
          pia_pkg::ADDR_PHY_IDENTIFIER_LOW:    prdata <= {16'h0000, id_low};
          pia_pkg::ADDR_AUTONEG_ADVERTISEMENT: prdata <= {16'h0000, adv_ff};
          default:                             prdata <= 32'h0000_0000;
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_rsvd_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
    adv_ff[14] == 1'b0 && adv_ff[12:11] == 2'b00) else $error("reserved advert bits set");
  a_t4_fixed_zero: assert property (@(posedge pclk) disable iff (!presetn)
    advert_word[pia_pkg::ADV_T4_BIT] == 1'b0) else $error("T4 ability advertised");
  a_word_follows_reg: assert property (@(posedge pclk) disable iff (!presetn)
    advert_word == adv_ff) else $error("advert word differs from register");
  a_np_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    wr_adv && pstrb[1] |=> adv_ff[15] == $past(pwdata[15]) && adv_ff[13] == $past(pwdata[13]))
    else $error("next page or fault write lost");
  a_sel_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    wr_adv && pstrb[0] |=> adv_ff[4:0] == $past(pwdata[4:0])) else $error("selector write lost");
  a_strap_pause_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_cnt_ff == 2'h2 && !strap_loaded_ff && !wr_adv |=> adv_ff[10] == $past(strap_sync_ff.pause_en))
    else $error("pause strap not loaded");
  a_strap_speed_load: assert property (@(posedge pclk) disable iff (!presetn)
    load_cnt_ff == 2'h2 && !strap_loaded_ff && !wr_adv |=> adv_ff[8:5] == $past({strap_sync_ff.fast_fd,
    strap_sync_ff.fast_hd, strap_sync_ff.slow_fd, strap_sync_ff.slow_hd})) else $error("speed straps not loaded");
  a_strap_once_only: assert property (@(posedge pclk) disable iff (!presetn)
    strap_loaded_ff && !wr_adv |=> $stable(adv_ff)) else $error("advert changed without write");
  a_idhigh_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == pia_pkg::ADDR_PHY_IDENTIFIER_HIGH |=> prdata == {16'h0000, ORG_ID_HIGH} && pready)
    else $error("id high read wrong");
  a_idlow_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup && !pwrite && paddr == pia_pkg::ADDR_PHY_IDENTIFIER_LOW |=> prdata[15:0] == {ORG_ID_LOW, MODEL_NUM, REVISION})
    else $error("id low read wrong");

  // ----------------------------------------------------------------
  // Sequences for multi-step checks
  // ----------------------------------------------------------------
  sequence s_setup_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  sequence s_adv_wr_lane(int lane);
    wr_adv && pstrb[lane];
  endsequence

  sequence s_adv_wr_no_lane(int lane);
    wr_adv && !pstrb[lane] && !(load_cnt_ff == 2'h2 && !strap_loaded_ff);
  endsequence

  sequence s_pready_pulse;
    pready ##1 !pready;
  endsequence

  // ----------------------------------------------------------------
  // Identifier read checks
  // ----------------------------------------------------------------
  a_idhigh_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_HIGH) |=> !pslverr && prdata[31:16] == 16'h0000)
    else $error("id high read flagged or upper half set");

  a_idhigh_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_HIGH) |=> s_pready_pulse)
    else $error("id high answer not a single pulse");

  a_idlow_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_LOW) |=> !pslverr && pready)
    else $error("id low read flagged");

  a_idlow_org_field: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_LOW) |=> prdata[15:10] == ORG_ID_LOW)
    else $error("organisation field wrong");

  a_idlow_model_field: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_LOW) |=> prdata[9:4] == MODEL_NUM)
    else $error("model field wrong");

  a_idlow_rev_field: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_PHY_IDENTIFIER_LOW) |=> prdata[3:0] == REVISION)
    else $error("revision field wrong");

  // ----------------------------------------------------------------
  // Advertisement read and write checks
  // ----------------------------------------------------------------
  a_adv_read_value: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_AUTONEG_ADVERTISEMENT) |=> prdata == {16'h0000, $past(adv_ff)})
    else $error("advert read differs from register");

  a_adv_read_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_AUTONEG_ADVERTISEMENT) |=> prdata[14] == 1'b0 && prdata[12:11] == 2'b00)
    else $error("reserved advert bits read as set");

  a_adv_read_t4: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_rd(pia_pkg::ADDR_AUTONEG_ADVERTISEMENT) |=> prdata[9] == 1'b0)
    else $error("T4 bit read as set");

  a_rsvd14_drop: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(1) |=> adv_ff[14] == 1'b0)
    else $error("bit 14 took a write");

  a_rsvd12_drop: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(1) |=> adv_ff[12:11] == 2'b00)
    else $error("bits 12:11 took a write");

  a_t4_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(1) |=> adv_ff[9] == 1'b0)
    else $error("T4 bit took a write");

  a_pause_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(1) |=> adv_ff[10] == $past(pwdata[10]))
    else $error("pause write lost");

  a_fast_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(0) ##0 pstrb[1] |=> adv_ff[8:7] == $past(pwdata[8:7]))
    else $error("fast ability write lost");

  a_fast_hd_takes: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(0) |=> adv_ff[7] == $past(pwdata[7]))
    else $error("fast half duplex write lost");

  a_slow_write_takes: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(0) |=> adv_ff[6:5] == $past(pwdata[6:5]))
    else $error("slow ability write lost");

  a_high_lane_kept: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_no_lane(1) |=> adv_ff[15:8] == $past(adv_ff[15:8]))
    else $error("high lane moved without strobe");

  a_low_lane_kept: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_no_lane(0) |=> adv_ff[7:0] == $past(adv_ff[7:0]))
    else $error("low lane moved without strobe");

  a_word_on_write: assert property (@(posedge pclk) disable iff (!presetn)
    s_adv_wr_lane(0) |=> advert_word[4:0] == $past(pwdata[4:0]))
    else $error("ability word missed a selector write");

  a_word_hold: assert property (@(posedge pclk) disable iff (!presetn)
    strap_loaded_ff && !wr_adv |=> $stable(advert_word))
    else $error("ability word moved without write");

  // ----------------------------------------------------------------
  // Reset and strap checks
  // ----------------------------------------------------------------
  a_reset_word: assert property (@(posedge pclk)
    !presetn |-> advert_word == {11'h000, pia_pkg::SELECTOR_RESET})
    else $error("ability word not at reset value");

  a_load_not_early: assert property (@(posedge pclk) disable iff (!presetn)
    load_cnt_ff != 2'h2 |-> !strap_loaded_ff)
    else $error("strap load flagged too early");

  a_load_sticks: assert property (@(posedge pclk) disable iff (!presetn)
    strap_loaded_ff |=> strap_loaded_ff && load_cnt_ff == 2'h2)
    else $error("strap load flag dropped");

endmodule : pia_regs

`default_nettype wire

// ==== core/pia_pkg.sv ====
// Package for the PHY identifier and advertisement register bank.
// Assumes an APB slave with 32-bit data; registers are 16 bits in the low half.
package pia_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0]  IDX_PHY_IDENTIFIER_HIGH   = 5'h02;
  localparam logic [4:0]  IDX_PHY_IDENTIFIER_LOW    = 5'h03;
  localparam logic [4:0]  IDX_AUTONEG_ADVERTISEMENT = 5'h04;
  localparam logic [11:0] ADDR_PHY_IDENTIFIER_HIGH   = {5'h00, IDX_PHY_IDENTIFIER_HIGH, 2'b00};
  localparam logic [11:0] ADDR_PHY_IDENTIFIER_LOW    = {5'h00, IDX_PHY_IDENTIFIER_LOW, 2'b00};
  localparam logic [11:0] ADDR_AUTONEG_ADVERTISEMENT = {5'h00, IDX_AUTONEG_ADVERTISEMENT, 2'b00};

  // ----------------------------------------------------------------
  // Advertisement field positions and reset values
  // ----------------------------------------------------------------
  localparam int          ADV_NEXT_PAGE_BIT   = 15;
  localparam int          ADV_RSVD14_BIT      = 14;
  localparam int          ADV_REMOTE_FAULT_BIT = 13;
  localparam int          ADV_PAUSE_BIT       = 10;
  localparam int          ADV_T4_BIT          = 9;
  localparam int          ADV_FAST_FD_BIT     = 8;
  localparam int          ADV_FAST_HD_BIT     = 7;
  localparam int          ADV_SLOW_FD_BIT     = 6;
  localparam int          ADV_SLOW_HD_BIT     = 5;
  localparam logic [4:0]  SELECTOR_RESET      = 5'h01;
  // Bits software may change: 15, 13, 10, 8:0 except the fixed T4 bit
  localparam logic [15:0] ADV_WRITE_MASK      = 16'ha5ff & ~16'h0200;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pause_en;
    logic fast_fd;
    logic fast_hd;
    logic slow_fd;
    logic slow_hd;
  } pia_strap_type;

  typedef struct packed {
    logic [5:0] org_id_low_bits;
    logic [5:0] vendor_model_number;
    logic [3:0] model_revision_number;
  } pia_id_low_type;

endpackage : pia_pkg

// ==== test/pia_link_partner.sv ====
// Link partner model: receives the advertised ability word.
// Assumes the word is a level that the partner samples on every rising pclk edge.
`timescale 1ns/10ps
`default_nettype none
module pia_link_partner (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Ability word seen on the link
  input  wire logic [15:0] advert_word,
  output logic      [15:0] rx_word
);
  // Capture lags one cycle, as a real receiver would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_word <= 16'h0000;
    else rx_word <= advert_word;
  end
endmodule : pia_link_partner
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the identifier and advertisement registers.
// Assumes one 100 MHz clock and an APB master that waits for pready.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] ORG_HI = 16'h4c2d; // Arbitrary value
  localparam logic [5:0]  ORG_LO = 6'h2b;    // Arbitrary value
  localparam logic [5:0]  MODEL  = 6'h13;    // Arbitrary value
  localparam logic [3:0]  REV    = 4'h6;     // Arbitrary value
  logic                   pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0, prdata, rd, lf = 32'h9dd21ba0;
  logic [3:0]             pstrb = 4'hf, st;
  logic                   pready, pslverr, err;
  logic [15:0]            advert_word, rx_word, exp, wd;
  pia_pkg::pia_strap_type straps = '0;
  int                     error_cnt = 0, checked = 0;

  always #5 pclk = ~pclk;

  pia_regs #(.ORG_ID_HIGH(ORG_HI), .ORG_ID_LOW(ORG_LO), .MODEL_NUM(MODEL), .REVISION(REV)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strap_pins(straps), .advert_word(advert_word));
  pia_link_partner u_partner (.pclk(pclk), .presetn(presetn), .advert_word(advert_word), .rx_word(rx_word));

  function logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Only enabled lanes and writable bits move
  function logic [15:0] adv_after(input logic [15:0] old, input logic [15:0] w, input logic [3:0] s);
    logic [15:0] m;
    m = pia_pkg::ADV_WRITE_MASK & {{8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (w & m);
  endfunction : adv_after

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk

  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // APB master: setup, then access held until pready
  // ------------------------------------------------------------
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      error_cnt++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task do_reset;
    presetn <= 1'b0;
    lf = lfsr_next(lf);
    straps <= lf[4:0];
    repeat (5) @(posedge pclk);
    chk("reset advert", advert_word, 32'h1);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    exp = {5'h00, straps.pause_en, 1'b0, straps[3:0], pia_pkg::SELECTOR_RESET};
    chk("strap advert", advert_word, exp);
    apb(1'b0, pia_pkg::ADDR_AUTONEG_ADVERTISEMENT, 32'h0, 4'hf);
    chk("strap read", rd, exp);
    chk("strap read error", err, 32'h0);
  endtask : do_reset

  initial begin
    do_reset();
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, pia_pkg::ADDR_PHY_IDENTIFIER_HIGH, 32'hffffffff, 4'hf);
      apb(1'b0, pia_pkg::ADDR_PHY_IDENTIFIER_HIGH, 32'h0, 4'hf);
      chk("id high", rd, {16'h0, ORG_HI});
      apb(1'b1, pia_pkg::ADDR_PHY_IDENTIFIER_LOW, 32'h0, 4'hf);
      apb(1'b0, pia_pkg::ADDR_PHY_IDENTIFIER_LOW, 32'h0, 4'hf);
      chk("id low", rd, {16'h0, ORG_LO, MODEL, REV});
    end
    apb(1'b1, 12'h014, 32'hffff, 4'hf);
    chk("unmapped error", err, 32'h1);
    apb(1'b0, 12'h014, 32'h0, 4'hf);
    chk("unmapped read", rd, 32'h0);
    // Two fixed corners, then random words and lanes, with a reset midway
    for (int i = 0; i < 24; i++) begin
      lf = lfsr_next(lf);
      wd = (i == 0) ? 16'he7ff : (i == 1) ? 16'h0000 : lf[15:0] & ~16'h1800;
      st = (i < 2) ? 4'hf : lf[19:16];
      exp = adv_after(exp, wd, st);
      apb(1'b1, pia_pkg::ADDR_AUTONEG_ADVERTISEMENT, {lf[31:16], wd}, st);
      #1;
      chk("advert word", advert_word, exp);
      @(posedge pclk);
      #1;
      chk("partner word", rx_word, exp);
      apb(1'b0, pia_pkg::ADDR_AUTONEG_ADVERTISEMENT, 32'h0, 4'hf);
      chk("advert read", rd, exp);
      if (i == 12) do_reset();
    end
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
